//--- core/fcsm_pkg.sv
// Package: states, command codes, bus cycle and output mode types for the command sequencer
package fcsm_pkg;
   localparam int unsigned DATA_W   = 16;            // Flash data bus width
   localparam int unsigned ADDR_W   = 23;            // Word address width
   localparam int unsigned BLOCK_LSB = 16;           // Block number starts here
   localparam int unsigned BANK_LSB  = 19;           // Bank number starts here
   localparam int unsigned NBANKS    = 16;           // Banks in the array
   localparam int unsigned CNT_W     = 5;            // Word count width (N-1)

   // Command codes
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_OTP_SETUP  = 8'hc0;
   localparam logic [7:0] CMD_LOCK_CONF  = 8'h01;
   localparam logic [7:0] CMD_LOCKDN_CONF = 8'h2f;
   localparam logic [7:0] CMD_SETCFG_CONF = 8'h03;
   localparam logic [7:0] CMD_BUF_PROG   = 8'he8;
   localparam logic [7:0] CMD_BUFFERED_FACTORY_PROGRAM_SETUP = 8'h80;
   localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_SR    = 8'h70;
   localparam logic [7:0] CMD_CLR_SR     = 8'h50;
   localparam logic [7:0] CMD_PROG       = 8'h40;
   localparam logic [7:0] CMD_ERASE      = 8'h20;
   localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
   localparam logic [DATA_W-1:0] BUFFERED_FACTORY_PROGRAM_EXIT_WORD = 16'hffff;
   localparam logic [CNT_W-1:0]  CNT_ZERO = 5'h00;

   // Command interface states
   typedef enum logic [4:0] {
      FCSM_READY      = 5'h00,
      FCSM_LOCK_SETUP = 5'h01,
      FCSM_OTP_SETUP  = 5'h02,
      FCSM_BP_SETUP   = 5'h03,
      FCSM_BP_LOAD1   = 5'h04,
      FCSM_BP_LOAD2   = 5'h05,
      FCSM_BP_CONFIRM = 5'h06,
      FCSM_BUSY       = 5'h07,
      FCSM_ES         = 5'h08,
      FCSM_ES_LOCK    = 5'h09,
      FCSM_ES_BP_SETUP = 5'h0a,
      FCSM_ES_BP_LOAD1 = 5'h0b,
      FCSM_ES_BP_LOAD2 = 5'h0c,
      FCSM_ES_BP_CONFIRM = 5'h0d,
      FCSM_ES_BUSY    = 5'h0e,
      FCSM_BUFFERED_FACTORY_PROGRAM_SETUP = 5'h0f,
      FCSM_BUFFERED_FACTORY_PROGRAM_BUSY  = 5'h10,
      FCSM_ILLEGAL    = 5'h11
   } fcsm_state_t;

   // Per-bank output mode
   typedef enum logic [0:0] {
      FCSM_OUT_ARRAY  = 1'b0,
      FCSM_OUT_STATUS = 1'b1
   } fcsm_out_t;

   // One host bus write cycle
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcsm_wr_t;

   // Events towards the program/erase controller
   typedef struct packed {
      logic start_prog;     // Load data into the array engine
      logic seq_error;      // Sequence or lock error
      logic bp_fail;        // Buffer words crossed blocks
   } fcsm_evt_t;

   localparam fcsm_state_t STATE_RST = FCSM_READY;
endpackage

//--- core/fcsm_core.sv
// Command interface sequencer: buffer, factory program and lock setup handling
// Contract
// [R1] Lock and OTP setup ignored while controller busy
// [R2] Factory mode exits on all-ones word, other block
// [R3] Undefined codes take the illegal-command path
// [R4] Unavailable inputs leave state unchanged
// [R5] Zero count goes to confirm, else load2
// [R6] Same count logic during erase suspend
// [R7] Factory mode accepted only if status bit zero low
// [R8] Factory busy in first block; writes are data
// [R9] Buffer program fails on block mismatch
// [R10] Output mode matters only in command bank
// [R11] Banks hold output mode until new command
// [R12] Suspend lock setup returns to suspend, errors
// [R13] Setup and busy states read status register
// [R14] Suspend set-config confirm selects array output
`timescale 1ns/10ps
module fcsm_core (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       ce_i,
   input  wire fcsm_pkg::fcsm_wr_t         wr_i,
   input  wire logic [fcsm_pkg::ADDR_W-1:0] rd_addr_i,
   input  wire logic                       pec_busy_i,
   input  wire logic                       pec_done_i,
   input  wire logic                       status_bit_zero_i,
   output logic                            status_sel_o,
   output fcsm_pkg::fcsm_state_t           state_o,
   output fcsm_pkg::fcsm_evt_t             evt_o
);
   ////////////////////////////////////////////////////////////////
   // All state in one packed struct
   typedef struct packed {
      fcsm_pkg::fcsm_state_t               st;
      logic [fcsm_pkg::CNT_W-1:0]          cnt;
      logic [fcsm_pkg::ADDR_W-fcsm_pkg::BLOCK_LSB-1:0] blk;
      logic                                blk_err;
      logic [fcsm_pkg::NBANKS-1:0]         mode;
      fcsm_pkg::fcsm_evt_t                 evt;
      logic                                status_sel;
   } fcsm_regs_t;

   fcsm_regs_t q, d;                      // Registered state and next
   logic [7:0]  cmd;                      // Low byte carries the command
   logic [3:0]  wbank;                    // Bank of the write
   logic [3:0]  rbank;                    // Bank of the read
   logic [fcsm_pkg::ADDR_W-fcsm_pkg::BLOCK_LSB-1:0] wblk; // Block of the write
   logic        known;                    // Code in defined set
   logic        set_status;               // Command bank goes to status
   logic        set_array;                // Command bank goes to array

   assign cmd   = wr_i.data[7:0];
   assign wbank = wr_i.addr[fcsm_pkg::ADDR_W-1:fcsm_pkg::BANK_LSB];
   assign rbank = rd_addr_i[fcsm_pkg::ADDR_W-1:fcsm_pkg::BANK_LSB];
   assign wblk  = wr_i.addr[fcsm_pkg::ADDR_W-1:fcsm_pkg::BLOCK_LSB];

   ////////////////////////////////////////////////////////////////
   // Decode of the defined command set
   always_comb begin
      case (cmd)
         fcsm_pkg::CMD_LOCK_SETUP, fcsm_pkg::CMD_OTP_SETUP, fcsm_pkg::CMD_LOCK_CONF,
         fcsm_pkg::CMD_LOCKDN_CONF, fcsm_pkg::CMD_SETCFG_CONF, fcsm_pkg::CMD_BUF_PROG,
         fcsm_pkg::CMD_BUFFERED_FACTORY_PROGRAM_SETUP, fcsm_pkg::CMD_CONFIRM, fcsm_pkg::CMD_READ_ARRAY,
         fcsm_pkg::CMD_READ_SR, fcsm_pkg::CMD_CLR_SR, fcsm_pkg::CMD_PROG,
         fcsm_pkg::CMD_ERASE, fcsm_pkg::CMD_SUSPEND: known = 1'b1;
         default: known = 1'b0; // [R3]
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Next-state logic; output modes never feed state decisions
   always_comb begin
      d = q;
      d.evt = '0;
      set_status = 1'b0;
      set_array  = 1'b0;
      if (wr_i.valid) begin
         case (q.st)
            fcsm_pkg::FCSM_READY: begin
               set_status = 1'b1;
               if (!known) begin
                  d.st = fcsm_pkg::FCSM_ILLEGAL; // [R3]
               end else if (pec_busy_i &&
                  (cmd == fcsm_pkg::CMD_LOCK_SETUP || cmd == fcsm_pkg::CMD_OTP_SETUP)) begin
                  set_status = 1'b0; // Whole cycle ignored [R1]
               end else begin
                  case (cmd)
                     fcsm_pkg::CMD_LOCK_SETUP: d.st = fcsm_pkg::FCSM_LOCK_SETUP;
                     fcsm_pkg::CMD_OTP_SETUP:  d.st = fcsm_pkg::FCSM_OTP_SETUP;
                     fcsm_pkg::CMD_BUF_PROG:   d.st = fcsm_pkg::FCSM_BP_SETUP;
                     fcsm_pkg::CMD_BUFFERED_FACTORY_PROGRAM_SETUP: begin
                        if (!status_bit_zero_i) begin
                           d.st = fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_SETUP; // [R7]
                        end else begin
                           d.evt.seq_error = 1'b1; // Refused [R7]
                        end
                     end
                     fcsm_pkg::CMD_READ_ARRAY: begin
                        set_status = 1'b0;
                        set_array  = 1'b1;
                     end
                     default: d.st = q.st; // [R4]
                  endcase
               end
            end
            fcsm_pkg::FCSM_LOCK_SETUP, fcsm_pkg::FCSM_OTP_SETUP: begin
               // Second cycle of the pair, also ignored if busy [R1]
               if (!pec_busy_i) begin
                  set_status = 1'b1; // [R13]
                  if (q.st == fcsm_pkg::FCSM_LOCK_SETUP &&
                      cmd == fcsm_pkg::CMD_SETCFG_CONF) begin
                     set_status = 1'b0;
                     set_array  = 1'b1;
                     d.st = fcsm_pkg::FCSM_READY;
                  end else begin
                     d.st = fcsm_pkg::FCSM_BUSY;
                     d.evt.start_prog = 1'b1;
                  end
               end
            end
            fcsm_pkg::FCSM_BP_SETUP, fcsm_pkg::FCSM_ES_BP_SETUP: begin
               set_status = 1'b1; // [R13]
               d.cnt = wr_i.data[fcsm_pkg::CNT_W-1:0];
               d.blk = wblk;
               d.blk_err = 1'b0;
               d.st = (q.st == fcsm_pkg::FCSM_BP_SETUP) ?
                      fcsm_pkg::FCSM_BP_LOAD1 : fcsm_pkg::FCSM_ES_BP_LOAD1;
            end
            fcsm_pkg::FCSM_BP_LOAD1, fcsm_pkg::FCSM_BP_LOAD2,
            fcsm_pkg::FCSM_ES_BP_LOAD1, fcsm_pkg::FCSM_ES_BP_LOAD2: begin
               set_status = 1'b1;
               if (q.st == fcsm_pkg::FCSM_BP_LOAD1 || q.st == fcsm_pkg::FCSM_ES_BP_LOAD1) begin
                  d.blk = wblk;
               end else if (wblk != q.blk) begin
                  d.blk_err = 1'b1; // [R9]
               end
               if (q.cnt == fcsm_pkg::CNT_ZERO) begin
                  d.st = (q.st == fcsm_pkg::FCSM_BP_LOAD1 || q.st == fcsm_pkg::FCSM_BP_LOAD2)
                         ? fcsm_pkg::FCSM_BP_CONFIRM : fcsm_pkg::FCSM_ES_BP_CONFIRM; // [R5] [R6]
               end else begin
                  d.cnt = q.cnt - 5'h01;
                  d.st = (q.st == fcsm_pkg::FCSM_BP_LOAD1 || q.st == fcsm_pkg::FCSM_BP_LOAD2)
                         ? fcsm_pkg::FCSM_BP_LOAD2 : fcsm_pkg::FCSM_ES_BP_LOAD2; // [R5] [R6]
               end
            end
            fcsm_pkg::FCSM_BP_CONFIRM, fcsm_pkg::FCSM_ES_BP_CONFIRM: begin
               set_status = 1'b1;
               if (cmd == fcsm_pkg::CMD_CONFIRM && !q.blk_err) begin
                  d.evt.start_prog = 1'b1;
                  d.st = (q.st == fcsm_pkg::FCSM_BP_CONFIRM) ?
                         fcsm_pkg::FCSM_BUSY : fcsm_pkg::FCSM_ES_BUSY;
               end else begin
                  d.evt.seq_error = ~q.blk_err;
                  d.evt.bp_fail   = q.blk_err; // [R9]
                  d.st = (q.st == fcsm_pkg::FCSM_BP_CONFIRM) ?
                         fcsm_pkg::FCSM_READY : fcsm_pkg::FCSM_ES;
               end
            end
            fcsm_pkg::FCSM_BUSY: begin
               // Suspend pauses the running operation; other inputs unavailable [R4]
               if (cmd == fcsm_pkg::CMD_SUSPEND) begin
                  set_status = 1'b1; // [R13]
                  d.st = fcsm_pkg::FCSM_ES;
               end
            end
            fcsm_pkg::FCSM_ES: begin
               set_status = 1'b1;
               case (cmd)
                  fcsm_pkg::CMD_LOCK_SETUP: d.st = fcsm_pkg::FCSM_ES_LOCK;
                  fcsm_pkg::CMD_BUF_PROG:   d.st = fcsm_pkg::FCSM_ES_BP_SETUP;
                  fcsm_pkg::CMD_CONFIRM:    d.st = fcsm_pkg::FCSM_BUSY;
                  default: begin
                     if (!known) begin
                        d.st = fcsm_pkg::FCSM_ILLEGAL; // [R3]
                     end
                  end
               endcase
            end
            fcsm_pkg::FCSM_ES_LOCK: begin
               d.st = fcsm_pkg::FCSM_ES; // [R12]
               set_status = 1'b1; // [R13]
               if (cmd == fcsm_pkg::CMD_SETCFG_CONF) begin
                  set_status = 1'b0;
                  set_array  = 1'b1; // [R14]
               end else if (cmd != fcsm_pkg::CMD_LOCK_CONF &&
                            cmd != fcsm_pkg::CMD_LOCKDN_CONF) begin
                  d.evt.seq_error = 1'b1; // Lock error [R12]
               end
            end
            fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_SETUP: begin
               set_status = 1'b1;
               d.blk = wblk;
               d.evt.start_prog = 1'b1;
               d.st = fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY;
            end
            fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY: begin
               set_status = 1'b1; // [R8]
               if (wblk != q.blk && wr_i.data == fcsm_pkg::BUFFERED_FACTORY_PROGRAM_EXIT_WORD) begin
                  d.st = fcsm_pkg::FCSM_BUSY; // [R2]
               end else begin
                  d.evt.start_prog = 1'b1; // Any word is data [R8]
               end
            end
            fcsm_pkg::FCSM_ILLEGAL: begin
               if (cmd == fcsm_pkg::CMD_READ_ARRAY || cmd == fcsm_pkg::CMD_CLR_SR) begin
                  d.st = fcsm_pkg::FCSM_READY;
                  set_array = (cmd == fcsm_pkg::CMD_READ_ARRAY);
               end
            end
            default: d.st = q.st; // Unavailable input [R4]
         endcase
      end else if (pec_done_i) begin
         if (q.st == fcsm_pkg::FCSM_BUSY) d.st = fcsm_pkg::FCSM_READY;
         if (q.st == fcsm_pkg::FCSM_ES_BUSY) d.st = fcsm_pkg::FCSM_ES;
      end
      // Only the bank that received the command changes mode [R11]
      if (set_status) d.mode[wbank] = fcsm_pkg::FCSM_OUT_STATUS;
      if (set_array)  d.mode[wbank] = fcsm_pkg::FCSM_OUT_ARRAY;
      // Status only read in a bank whose mode says so [R10]
      d.status_sel = d.mode[rbank];
   end

   ////////////////////////////////////////////////////////////////
   // State register with clock enable
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '{st: fcsm_pkg::STATE_RST, default: '0};
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign status_sel_o = q.status_sel;
   assign state_o      = q.st;
   assign evt_o        = q.evt;

   ////////////////////////////////////////////////////////////////
   // Checks
   chk_busy_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
      ce_i && wr_i.valid && pec_busy_i && q.st == fcsm_pkg::FCSM_READY &&
      wr_i.data[7:0] == fcsm_pkg::CMD_LOCK_SETUP |=> q.st == fcsm_pkg::FCSM_READY)
      else $error("lock setup taken while busy");
   chk_buffered_factory_program_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY && wblk == q.blk
      |=> q.st == fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY)
      else $error("factory mode left in first block");
   chk_illegal_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_READY && !known
      |=> q.st == fcsm_pkg::FCSM_ILLEGAL)
      else $error("illegal code not trapped");
   chk_count_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_BP_LOAD2 && q.cnt == fcsm_pkg::CNT_ZERO
      |=> q.st == fcsm_pkg::FCSM_BP_CONFIRM)
      else $error("zero count did not confirm");
   chk_es_count: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_ES_BP_LOAD1 && q.cnt != fcsm_pkg::CNT_ZERO
      |=> q.st == fcsm_pkg::FCSM_ES_BP_LOAD2)
      else $error("suspend count path wrong");
   chk_buffered_factory_program_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_READY && status_bit_zero_i
      |=> q.st != fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_SETUP)
      else $error("factory mode entered with bit set");
   chk_blk_fail: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_BP_CONFIRM && q.blk_err
      |=> evt_o.bp_fail && q.st == fcsm_pkg::FCSM_READY)
      else $error("block mismatch not failed");
   chk_es_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      ce_i && wr_i.valid && q.st == fcsm_pkg::FCSM_ES_LOCK
      |=> q.st == fcsm_pkg::FCSM_ES)
      else $error("suspend lock setup not returned");
   cov_bp_run: cover property (@(posedge clk_i) q.st == fcsm_pkg::FCSM_BP_CONFIRM);
   cov_buffered_factory_program: cover property (@(posedge clk_i) q.st == fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY);
   cov_es_bp: cover property (@(posedge clk_i) q.st == fcsm_pkg::FCSM_ES_BP_CONFIRM);
   cov_suspend: cover property (@(posedge clk_i) q.st == fcsm_pkg::FCSM_ES);
endmodule

//--- verification/fcsm_pec_model.sv
// Program/erase controller model: busy span after a start pulse, then a done pulse
`timescale 1ns/10ps
module fcsm_pec_model #(
   parameter int unsigned BUSY_CYC = 12 // Cycles of one array operation
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,   // Start pulse from the sequencer
   input  wire logic suspend_i, // Sequencer sits in a suspend state
   output logic      busy_o,    // Level while an operation runs
   output logic      done_o     // One-cycle completion pulse
);
   int unsigned left_q; // Cycles still to run
   logic        run_q;  // Operation in flight
   // Busy drops while suspended; the core checks busy only in ready and the lock/OTP setup states
   assign busy_o = run_q & ~suspend_i;
   ////////////////////////////////////////////////////////////////////////
   // Counter frozen during suspend so no done pulse lands there
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (!rst_n_i) begin
         run_q <= 1'b0;
         left_q <= 0;
      end else if (start_i && !run_q) begin
         run_q <= 1'b1;
         left_q <= BUSY_CYC;
      end else if (run_q && !suspend_i) begin
         if (left_q == 1) begin
            run_q <= 1'b0;
            done_o <= 1'b1;
         end else begin
            left_q <= left_q - 1;
         end
      end
   end
endmodule

//--- verification/flash_command_state_machine_tb.sv
// Testbench for the command sequencer, host driven by hand-written scenario tasks
`timescale 1ns/10ps
module flash_command_state_machine_tb;
   localparam logic [22:0] A_FIRST = 23'h010000; // Block 1, bank 0
   localparam logic [22:0] A_OTHER = 23'h020000; // Block 2, bank 0
   localparam logic [22:0] A_BANK2 = 23'h100000; // Bank 2
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic status_bit_zero_i = 1'b0;
   logic [22:0] rd_addr_i = A_FIRST;
   fcsm_pkg::fcsm_wr_t wr_i = '0;
   logic pec_busy_i, pec_done_i, status_sel_o, susp;
   fcsm_pkg::fcsm_state_t state_o;
   fcsm_pkg::fcsm_evt_t evt_o, ev;
   int fails = 0;
   int n_checks = 0;
   always #4 clk_i = ~clk_i;
   // Controller pauses in every suspend state except programming in suspend
   assign susp = state_o inside {fcsm_pkg::FCSM_ES, fcsm_pkg::FCSM_ES_LOCK,
      fcsm_pkg::FCSM_ES_BP_SETUP, fcsm_pkg::FCSM_ES_BP_LOAD1,
      fcsm_pkg::FCSM_ES_BP_LOAD2, fcsm_pkg::FCSM_ES_BP_CONFIRM};
   fcsm_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .wr_i(wr_i),
      .rd_addr_i(rd_addr_i), .pec_busy_i(pec_busy_i), .pec_done_i(pec_done_i),
      .status_bit_zero_i(status_bit_zero_i), .status_sel_o(status_sel_o),
      .state_o(state_o), .evt_o(evt_o));
   fcsm_pec_model pec (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(evt_o.start_prog),
      .suspend_i(susp), .busy_o(pec_busy_i), .done_o(pec_done_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk_st(input fcsm_pkg::fcsm_state_t exp);
      check("state", 32'(state_o), 32'(exp));
   endtask
   // One bus write; valid stays high so writes can run back to back
   task automatic wr(input logic [22:0] a, input logic [15:0] d);
      @(negedge clk_i);
      wr_i.valid = 1'b1;
      wr_i.addr = a;
      wr_i.data = d;
      @(posedge clk_i);
      #1;
      ev = evt_o;
   endtask
   task automatic wc(input logic [7:0] c);
      wr(A_FIRST, {8'h00, c});
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk_i);
         wr_i.valid = 1'b0;
      end
   endtask
   // Bounded wait for the controller to finish
   task automatic wait_ready();
      int i;
      i = 0;
      while (state_o !== fcsm_pkg::FCSM_READY && i < 100) begin
         @(negedge clk_i);
         i++;
      end
   endtask
   task automatic do_reset();
      idle(1);
      rst_n_i = 1'b0;
      idle(5);
      rst_n_i = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk_st(fcsm_pkg::FCSM_READY);
      check("status_sel", 32'(status_sel_o), 32'h0);
      check("evt", 32'(evt_o), 32'h0);
      $display("test reset done");
   endtask
   // Zero count path, read source by bank, setups refused while busy
   task automatic t_bp_zero();
      wc(fcsm_pkg::CMD_BUF_PROG);
      chk_st(fcsm_pkg::FCSM_BP_SETUP);
      wc(8'h00);
      chk_st(fcsm_pkg::FCSM_BP_LOAD1);
      wr(A_FIRST, 16'h1234);
      chk_st(fcsm_pkg::FCSM_BP_CONFIRM);
      idle(2);
      check("status_sel", 32'(status_sel_o), 32'h1);
      rd_addr_i = A_BANK2;
      idle(3);
      check("status_sel other bank", 32'(status_sel_o), 32'h0);
      rd_addr_i = A_FIRST;
      wc(fcsm_pkg::CMD_CONFIRM);
      chk_st(fcsm_pkg::FCSM_BUSY);
      check("start_prog", 32'(ev.start_prog), 32'h1);
      idle(3);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      chk_st(fcsm_pkg::FCSM_BUSY);
      wc(fcsm_pkg::CMD_OTP_SETUP);
      chk_st(fcsm_pkg::FCSM_BUSY);
      idle(1);
      wait_ready();
      chk_st(fcsm_pkg::FCSM_READY);
      $display("test buffer zero done");
   endtask
   // Nonzero count and a word from a foreign block
   task automatic t_bp_count();
      logic fail_seen;
      int i;
      fail_seen = 1'b0;
      wc(fcsm_pkg::CMD_BUF_PROG);
      wc(8'h01);
      wr(A_FIRST, 16'h0001);
      chk_st(fcsm_pkg::FCSM_BP_LOAD2);
      for (i = 0; i < 4; i++) begin
         if (state_o inside {fcsm_pkg::FCSM_BP_LOAD1, fcsm_pkg::FCSM_BP_LOAD2}) begin
            wr(A_OTHER, 16'h0002);
            fail_seen |= ev.bp_fail;
         end
      end
      if (state_o === fcsm_pkg::FCSM_BP_CONFIRM) begin
         wc(fcsm_pkg::CMD_CONFIRM);
         fail_seen |= ev.bp_fail;
      end
      check("bp_fail", 32'(fail_seen), 32'h1);
      do_reset();
      $display("test buffer count done");
   endtask
   // Undefined codes, unavailable input, frozen enable
   task automatic t_illegal();
      logic [7:0] codes [3] = '{8'h99, 8'h00, 8'h7f};
      @(negedge clk_i);
      ce_i = 1'b0;
      wc(8'h99);
      chk_st(fcsm_pkg::FCSM_READY);
      @(negedge clk_i);
      ce_i = 1'b1;
      wr_i.valid = 1'b0; // Frozen write must not be replayed once enabled
      foreach (codes[k]) begin
         wc(codes[k]);
         chk_st(fcsm_pkg::FCSM_ILLEGAL);
         wc(fcsm_pkg::CMD_CONFIRM);
         chk_st(fcsm_pkg::FCSM_ILLEGAL);
         wc(fcsm_pkg::CMD_READ_ARRAY);
         chk_st(fcsm_pkg::FCSM_READY);
      end
      $display("test illegal done");
   endtask
   // Factory mode entry, data handling and exit
   task automatic t_buffered_factory_program();
      idle(1);
      status_bit_zero_i = 1'b1;
      wc(fcsm_pkg::CMD_BUFFERED_FACTORY_PROGRAM_SETUP);
      check("seq_error", 32'(ev.seq_error), 32'h1);
      check("buffered_factory_program refused", 32'(state_o == fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_SETUP), 32'h0);
      wc(fcsm_pkg::CMD_READ_ARRAY);
      idle(1);
      status_bit_zero_i = 1'b0;
      wc(fcsm_pkg::CMD_BUFFERED_FACTORY_PROGRAM_SETUP);
      chk_st(fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_SETUP);
      wr(A_FIRST, 16'h1111);
      chk_st(fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      chk_st(fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY);
      wr(A_FIRST, fcsm_pkg::BUFFERED_FACTORY_PROGRAM_EXIT_WORD);
      chk_st(fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY);
      wr(A_OTHER, fcsm_pkg::BUFFERED_FACTORY_PROGRAM_EXIT_WORD);
      check("buffered_factory_program exit", 32'(state_o == fcsm_pkg::FCSM_BUFFERED_FACTORY_PROGRAM_BUSY), 32'h0);
      idle(1);
      wait_ready();
      chk_st(fcsm_pkg::FCSM_READY);
      $display("test factory done");
   endtask
   // Suspend: lock setup exits and buffer count logic
   task automatic t_suspend();
      wc(fcsm_pkg::CMD_BUF_PROG);
      wc(8'h00);
      wr(A_FIRST, 16'h4321);
      wc(fcsm_pkg::CMD_CONFIRM);
      idle(2);
      wc(fcsm_pkg::CMD_SUSPEND);
      chk_st(fcsm_pkg::FCSM_ES);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      chk_st(fcsm_pkg::FCSM_ES_LOCK);
      wc(fcsm_pkg::CMD_SETCFG_CONF);
      chk_st(fcsm_pkg::FCSM_ES);
      idle(2);
      check("status_sel setcfg", 32'(status_sel_o), 32'h0);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      wc(fcsm_pkg::CMD_LOCK_CONF);
      chk_st(fcsm_pkg::FCSM_ES);
      check("seq_error lock", 32'(ev.seq_error), 32'h0);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      wc(8'h55);
      chk_st(fcsm_pkg::FCSM_ES);
      check("seq_error other", 32'(ev.seq_error), 32'h1);
      wc(fcsm_pkg::CMD_BUF_PROG);
      chk_st(fcsm_pkg::FCSM_ES_BP_SETUP);
      wc(8'h01);
      chk_st(fcsm_pkg::FCSM_ES_BP_LOAD1);
      wr(A_FIRST, 16'h0abc);
      chk_st(fcsm_pkg::FCSM_ES_BP_LOAD2);
      wr(A_FIRST, 16'h0abd);
      chk_st(fcsm_pkg::FCSM_ES_BP_CONFIRM);
      // Leave suspend through the illegal state so the paused job runs on in ready
      wc(fcsm_pkg::CMD_READ_SR);
      chk_st(fcsm_pkg::FCSM_ES);
      wc(8'h99);
      chk_st(fcsm_pkg::FCSM_ILLEGAL);
      wc(fcsm_pkg::CMD_READ_ARRAY);
      chk_st(fcsm_pkg::FCSM_READY);
      check("pec busy", 32'(pec_busy_i), 32'h1);
      wc(fcsm_pkg::CMD_LOCK_SETUP);
      chk_st(fcsm_pkg::FCSM_READY);
      wc(fcsm_pkg::CMD_OTP_SETUP);
      chk_st(fcsm_pkg::FCSM_READY);
      do_reset();
      $display("test suspend done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Whole run is under two hundred cycles; this span is far beyond it
   initial begin
      #50000;
      fails++;
      print_verdict();
   end
   initial begin
      do_reset();
      t_reset();
      t_bp_zero();
      t_bp_count();
      t_illegal();
      t_buffered_factory_program();
      t_suspend();
      print_verdict();
   end
endmodule
